// >>> design/accel_sample_status_readout.sv
/*
 * Latest three-axis sample and data status registers with burst
 * auto-increment, fast-read skip and low-byte latching.
 * Assumes the serial front end decodes start, address, byte reads and
 * stop, and that the long sample FIFO and its status live elsewhere.
 */
// Summary of operation
// - mode zero: address 0 returns data status
// - bit 7 sets when any axis overwritten
// - bit 7 clears after all active highs read
// - bits 6..4 set on per-axis overwrite
// - per-axis overwrite clears on its high read
// - bit 3 sets on any enabled new sample
// - bit 3 clears after all enabled highs read
// - 14-bit samples at 0x01..0x06, high first
// - high holds 13..6, low 5..0 shifted up two
// - nonzero mode shows long fifo head instead
// - status plus six bytes auto-increment in burst
// - fast read skips every low byte, in mode zero only
// - low byte readable only right after high
// - high read latches matching low byte
// - fifo off only when both mode bits zero
// - auto-increment only in burst; stop clears it
`timescale 1ns/1ps
`include "accel_readout_map.svh"

module accel_sample_status_readout (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        addr_load,
    input  wire logic [7:0]  addr_value,
    input  wire logic        rd_strobe,
    input  wire logic        stop_seen,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    input  wire logic [1:0]  fifo_mode,
    input  wire logic        fast_read,
    input  wire logic [2:0]  axis_enable,
    input  wire logic        conv_valid,
    output logic             conv_ready,
    input  wire logic [2:0]  conv_axis,
    input  wire logic [13:0] conv_x,
    input  wire logic [13:0] conv_y,
    input  wire logic [13:0] conv_z,
    input  wire logic [13:0] head_x,
    input  wire logic [13:0] head_y,
    input  wire logic [13:0] head_z,
    input  wire logic [7:0]  fifo_status
);
    accel_readout_pkg::readout_state_s st;
    accel_readout_pkg::readout_state_s next_st;
    accel_readout_pkg::conv_word_s     in_word;
    accel_readout_pkg::conv_word_s     out_word;

    sample_stream_if #(.WIDTH(accel_readout_pkg::CONV_W)) to_stage ();
    sample_stream_if #(.WIDTH(accel_readout_pkg::CONV_W)) from_stage ();

    // conversion results wait in the staging buffer while reads run
    assign in_word.axis_new = conv_axis;
    assign in_word.value    = {conv_z, conv_y, conv_x};
    assign to_stage.valid   = conv_valid;
    assign to_stage.data    = in_word;
    assign conv_ready       = to_stage.ready;
    assign out_word         = from_stage.data;
    // a pending read wins; popping then would race the flag clear
    assign from_stage.ready = !rd_strobe;

    sample_stage_fifo #(
        .WIDTH (accel_readout_pkg::CONV_W),
        .DEPTH (`STAGE_DEPTH)
    ) u_stage (
        .ref_clk (ref_clk),
        .reset   (reset),
        .fill    (to_stage),
        .drain   (from_stage)
    );

    logic                           fifo_off;
    logic                           pop;
    logic [2:0]                     axis_new;
    logic [2:0]                     high_hit;
    logic [2:0]                     next_high_read;
    logic                           all_done;
    logic [7:0]                     eff_addr;
    logic [7:0]                     status_byte;
    logic [2:0][`SAMPLE_W-1:0]      src;
    logic [1:0]                     axis_sel;

    assign fifo_off = (fifo_mode == `FIFO_MODE_OFF);
    assign pop      = from_stage.valid && from_stage.ready;
    assign axis_new = pop ? (out_word.axis_new & axis_enable) : 3'h0;
    // a fresh address from the front end takes effect on the same byte
    assign eff_addr = addr_load ? addr_value : st.ptr;
    assign axis_sel = 2'((eff_addr - 8'h01) >> 1);

    // data source: live sample, or head of the long fifo
    always_comb begin
        if (fifo_off) begin
            src = st.sample;
        end else begin
            src = {head_z, head_y, head_x};
        end
    end

    // status byte layout
    always_comb begin
        status_byte = `RESET_BYTE;
        status_byte[`POS_ALL_OW] = st.all_overwrite;
        status_byte[`POS_Z_OW]   = st.overwrite[2];
        status_byte[`POS_Y_OW]   = st.overwrite[1];
        status_byte[`POS_X_OW]   = st.overwrite[0];
        status_byte[`POS_ALL_DR] = st.all_ready;
        status_byte[`POS_Z_DR]   = st.ready[2];
        status_byte[`POS_Y_DR]   = st.ready[1];
        status_byte[`POS_X_DR]   = st.ready[0];
    end

    // one bit per axis whose high byte is read this cycle
    always_comb begin
        high_hit = 3'h0;
        if (rd_strobe) begin
            high_hit[0] = (eff_addr == `ADDR_X_SAMPLE_HIGH);
            high_hit[1] = (eff_addr == `ADDR_Y_SAMPLE_HIGH);
            high_hit[2] = (eff_addr == `ADDR_Z_SAMPLE_HIGH);
        end
    end

    // a new sample re-opens its axis; a high read marks it retrieved
    assign next_high_read = (st.high_read | high_hit) & ~axis_new;
    assign all_done       = &(next_high_read | ~axis_enable);

    // next state
    always_comb begin
        next_st          = st;
        next_st.rd_valid = 1'b0;

        // sample capture and flag evaluation in one cycle
        for (int i = 0; i < `AXES; i++) begin
            if (axis_new[i]) begin
                next_st.sample[i] = out_word.value[i];
            end
            // set wins over the read that would clear
            next_st.ready[i]     = axis_new[i] ||
                                   (st.ready[i] && !high_hit[i]);
            next_st.overwrite[i] = (axis_new[i] && st.ready[i]) ||
                                   (st.overwrite[i] && !high_hit[i]);
        end
        next_st.high_read     = next_high_read;
        next_st.all_ready     = (|axis_new) ||
                                (st.all_ready && !all_done);
        next_st.all_overwrite = (|(axis_new & st.ready)) ||
                                (st.all_overwrite && !all_done);

        if (addr_load) begin
            next_st.ptr = addr_value;
        end

        // byte read from the current burst address
        if (rd_strobe) begin
            next_st.rd_valid  = 1'b1;
            next_st.rd_data   = `RESET_BYTE;
            next_st.low_armed = 1'b0;
            unique case (eff_addr)
                `ADDR_SAMPLE_STATUS: begin
                    next_st.rd_data = fifo_off ? status_byte : fifo_status;
                end
                `ADDR_X_SAMPLE_HIGH, `ADDR_Y_SAMPLE_HIGH, `ADDR_Z_SAMPLE_HIGH: begin
                    next_st.rd_data    = src[axis_sel][13:6];
                    next_st.low_hold   = src[axis_sel][5:0];
                    next_st.low_armed  = 1'b1;
                    next_st.armed_axis = axis_sel;
                end
                `ADDR_X_SAMPLE_LOW, `ADDR_Y_SAMPLE_LOW, `ADDR_Z_SAMPLE_LOW: begin
                    // random access to a low byte returns zero
                    if (st.low_armed && st.armed_axis == axis_sel) begin
                        next_st.rd_data = {st.low_hold, 2'h0};
                    end
                end
                default: begin
                    next_st.rd_data = `RESET_BYTE;
                end
            endcase
            // burst step; fast read hops over the low bytes when fifo_mode is zero
            if (fast_read && fifo_off &&
                (eff_addr == `ADDR_X_SAMPLE_HIGH ||
                 eff_addr == `ADDR_Y_SAMPLE_HIGH ||
                 eff_addr == `ADDR_Z_SAMPLE_HIGH)) begin
                next_st.ptr = eff_addr + 8'h02;
            end else begin
                next_st.ptr = eff_addr + 8'h01;
            end
        end

        // end of the burst forgets the stored address
        if (stop_seen) begin
            next_st.ptr = `RESET_ADDR;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data  = st.rd_data;
    assign rd_valid = st.rd_valid;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_x_high_read;
        rd_strobe && !addr_load && !stop_seen && st.ptr == `ADDR_X_SAMPLE_HIGH;
    endsequence

    sequence s_x_low_follows;
        rd_strobe && !addr_load && st.ptr == `ADDR_X_SAMPLE_LOW;
    endsequence

    property p_status_read;
        rd_strobe && fifo_off && eff_addr == `ADDR_SAMPLE_STATUS
            |=> rd_valid && rd_data == $past(status_byte);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status byte not returned at address zero");

    property p_overwrite_set;
        axis_new[0] && st.ready[0] |=> st.overwrite[0] && st.all_overwrite;
    endproperty
    a_overwrite_set: assert property (p_overwrite_set)
        else $error("overwrite flags not set by unread sample");

    property p_all_ow_hold;
        st.all_overwrite && !all_done |=> st.all_overwrite;
    endproperty
    a_all_ow_hold: assert property (p_all_ow_hold)
        else $error("combined overwrite cleared too early");

    property p_ow_clear;
        rd_strobe && high_hit[1] && !axis_new[1] |=> !st.overwrite[1] && !st.ready[1];
    endproperty
    a_ow_clear: assert property (p_ow_clear)
        else $error("y flags survived high byte read");

    property p_ready_set;
        |axis_new |=> st.all_ready ##0 (st.ready == ($past(st.ready) | $past(axis_new)));
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("ready flags not set by new sample");

    property p_all_ready_clear;
        st.all_ready && all_done && !(|axis_new) |=> !st.all_ready;
    endproperty
    a_all_ready_clear: assert property (p_all_ready_clear)
        else $error("combined ready not cleared after all highs");

    property p_low_pad;
        rd_strobe && (eff_addr == `ADDR_Y_SAMPLE_LOW) |=> rd_data[1:0] == 2'h0;
    endproperty
    a_low_pad: assert property (p_low_pad)
        else $error("low byte padding bits not zero");

    property p_fast_skip;
        rd_strobe && fast_read && fifo_off && !stop_seen &&
            eff_addr == `ADDR_Y_SAMPLE_HIGH |=> st.ptr == `ADDR_Z_SAMPLE_HIGH;
    endproperty
    a_fast_skip: assert property (p_fast_skip)
        else $error("fast read did not skip low byte");

    property p_random_low;
        rd_strobe && !st.low_armed && eff_addr == `ADDR_Z_SAMPLE_LOW
            |=> rd_data == `RESET_BYTE;
    endproperty
    a_random_low: assert property (p_random_low)
        else $error("unarmed low byte read returned data");

    property p_pair_latch;
        s_x_high_read ##1 s_x_low_follows
            |=> rd_data == {$past(src[0][5:0], 2), 2'h0};
    endproperty
    a_pair_latch: assert property (p_pair_latch)
        else $error("low byte not from same sample as high");

    property p_stop_clear;
        stop_seen |=> st.ptr == `RESET_ADDR;
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("stop did not clear burst address");

    property p_capture;
        axis_new[2] |=> st.sample[2] == $past(out_word.value[2]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("sample register not updated with flags");
endmodule

// >>> design/sample_stage_fifo.sv
/*
 * Small staging FIFO for conversion words, width and depth set by
 * parameters. Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module sample_stage_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    sample_stream_if.snk    fill,
    sample_stream_if.src    drain
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } fifo_state_s;

    fifo_state_s st;
    fifo_state_s next_st;
    logic [AW:0] used;
    logic        push;
    logic        pop;

    // pointers carry one extra bit so full and empty differ
    assign used        = st.wr - st.rd;
    assign fill.ready  = (used != (AW+1)'(DEPTH));
    assign drain.valid = (used != '0);
    assign drain.data  = st.mem[st.rd[AW-1:0]];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    // next state
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr[AW-1:0]] = fill.data;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> inc/accel_readout_map.svh
/*
 * Register offsets, field positions, reset values and sizes of the
 * sample and status readout. Assumes it is included by bare name.
 */
`ifndef ACCEL_READOUT_MAP_SVH
`define ACCEL_READOUT_MAP_SVH

// register offsets
`define ADDR_SAMPLE_STATUS 8'h00
`define ADDR_X_SAMPLE_HIGH 8'h01
`define ADDR_X_SAMPLE_LOW  8'h02
`define ADDR_Y_SAMPLE_HIGH 8'h03
`define ADDR_Y_SAMPLE_LOW  8'h04
`define ADDR_Z_SAMPLE_HIGH 8'h05
`define ADDR_Z_SAMPLE_LOW  8'h06
`define ADDR_FIFO_SETUP    8'h09
`define ADDR_CONTROL_ONE   8'h2a

// field positions
`define POS_ALL_OW         7
`define POS_Z_OW           6
`define POS_Y_OW           5
`define POS_X_OW           4
`define POS_ALL_DR         3
`define POS_Z_DR           2
`define POS_Y_DR           1
`define POS_X_DR           0
`define POS_FAST_READ      1
`define POS_FIFO_MODE_HI   7
`define POS_FIFO_MODE_LO   6

// widths and reset values
`define SAMPLE_W           14
`define AXES               3
`define STAGE_DEPTH        4
`define FIFO_MODE_OFF      2'h0
`define RESET_BYTE         8'h00
`define RESET_ADDR         8'h00

`endif

// >>> inc/accel_readout_pkg.sv
/*
 * Types shared by the readout block and its sample staging buffer.
 * Assumes accel_readout_map.svh is on the include path.
 */
`include "accel_readout_map.svh"

package accel_readout_pkg;

    typedef logic [`SAMPLE_W-1:0] sample_t;

    // one conversion result as it travels through the staging buffer
    typedef struct packed {
        logic [`AXES-1:0]           axis_new;
        logic [`AXES-1:0][`SAMPLE_W-1:0] value;
    } conv_word_s;

    localparam int CONV_W = $bits(conv_word_s);

    // complete state of the readout block
    typedef struct packed {
        logic [`AXES-1:0][`SAMPLE_W-1:0] sample;
        logic [`AXES-1:0]           ready;
        logic [`AXES-1:0]           overwrite;
        logic [`AXES-1:0]           high_read;
        logic                       all_ready;
        logic                       all_overwrite;
        logic [7:0]                 ptr;
        logic [5:0]                 low_hold;
        logic                       low_armed;
        logic [1:0]                 armed_axis;
        logic [7:0]                 rd_data;
        logic                       rd_valid;
    } readout_state_s;

endpackage

// >>> inc/sample_stream_if.sv
/*
 * Valid/ready stream carrying conversion words between modules.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/1ps

interface sample_stream_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> sim/accel_sample_status_readout_tb.sv
/*
 * Self-checking bench for the sample and status readout, with a
 * behavioural register model compared at every byte read.
 * Assumes the host model drives the read port and the bench feeds conversions.
 */
`timescale 1ns/1ps

module accel_sample_status_readout_tb;
    logic        ref_clk;
    logic        reset;
    logic        conv_valid;
    logic        conv_ready;
    logic        fast_read;
    logic        rd_valid;
    logic        addr_load;
    logic        rd_strobe;
    logic        stop_seen;
    logic [7:0]  addr_value;
    logic [7:0]  rd_data;
    logic [7:0]  fifo_status;
    logic [1:0]  fifo_mode;
    logic [2:0]  axis_enable;
    logic [2:0]  conv_axis;
    logic [13:0] cv[3];
    logic [13:0] hdv[3];
    logic [13:0] smp[3];
    logic [2:0]  rdy;
    logic [2:0]  ow;
    logic [2:0]  hr;
    logic        ardy;
    logic        aow;
    logic [7:0]  lat;
    logic [7:0]  ptr;
    logic [7:0]  exp_q[$];
    logic [7:0]  r;
    int          last;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          seed = 32'hf879;

    accel_sample_status_readout dut (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .addr_load   (addr_load),
        .addr_value  (addr_value),
        .rd_strobe   (rd_strobe),
        .stop_seen   (stop_seen),
        .rd_data     (rd_data),
        .rd_valid    (rd_valid),
        .fifo_mode   (fifo_mode),
        .fast_read   (fast_read),
        .axis_enable (axis_enable),
        .conv_valid  (conv_valid),
        .conv_ready  (conv_ready),
        .conv_axis   (conv_axis),
        .conv_x      (cv[0]),
        .conv_y      (cv[1]),
        .conv_z      (cv[2]),
        .head_x      (hdv[0]),
        .head_y      (hdv[1]),
        .head_z      (hdv[2]),
        .fifo_status (fifo_status)
    );

    host_read_model host (
        .ref_clk    (ref_clk),
        .rd_data    (rd_data),
        .rd_valid   (rd_valid),
        .addr_load  (addr_load),
        .addr_value (addr_value),
        .rd_strobe  (rd_strobe),
        .stop_seen  (stop_seen)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    // model of one byte read, with its side effects on flags and pointer
    function automatic logic [7:0] mread(input int a);
        logic [13:0] v;
        logic [7:0]  b;
        int          ax;
        b = 8'h00;
        ax = (a - 1) / 2;
        if (a == 0) begin
            b = (fifo_mode != 2'h0) ? fifo_status : {aow, ow, ardy, rdy};
        end else if (a == 1 || a == 3 || a == 5) begin
            v = (fifo_mode != 2'h0) ? hdv[ax] : smp[ax];
            b = v[13:6];
            lat = {v[5:0], 2'h0};
            rdy[ax] = 1'b0;
            ow[ax] = 1'b0;
            hr[ax] = 1'b1;
            if ((hr & axis_enable) == axis_enable) begin
                ardy = 1'b0;
                aow = 1'b0;
            end
        end else if ((a == 2 || a == 4 || a == 6) && last == a - 1) begin
            b = lat;
        end
        ptr = 8'(a + ((fast_read && fifo_mode == 2'h0 && a % 2 == 1 && a < 6) ? 2 : 1));
        last = a;
        return b;
    endfunction

    // offer one random word; valid drops while refused so no stale word is taken
    task automatic push(input logic [2:0] ax);
        int g;
        g = 0;
        while (conv_ready !== 1'b1 && g < 50) begin
            conv_valid = 1'b0;
            @(negedge ref_clk);
            g++;
        end
        // a buffer that never frees up counts as a mismatch, not a silent push
        chk_bit("conv_ready", 1'b1, conv_ready);
        conv_valid = 1'b1;
        conv_axis = ax;
        for (int a = 0; a < 3; a++) begin
            cv[a] = 14'($random(seed));
            if (ax[a] && axis_enable[a]) begin
                if (rdy[a]) begin
                    ow[a] = 1'b1;
                    aow = 1'b1;
                end
                smp[a] = cv[a];
                rdy[a] = 1'b1;
                hr[a] = 1'b0;
                ardy = 1'b1;
            end
        end
        @(negedge ref_clk);
    endtask

    // pops only happen on cycles without a strobe, so leave room to drain
    task automatic settle();
        conv_valid = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask

    task automatic check_reads();
        chk("read count", 8'(exp_q.size()), 8'(host.got.size()));
        while (exp_q.size() > 0 && host.got.size() > 0) begin
            chk("read byte", exp_q.pop_front(), host.got.pop_front());
        end
        exp_q.delete();
        host.got.delete();
    endtask

    task automatic expect_reads(input logic [7:0] s, input int n, input bit load);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mread((load && i == 0) ? int'(s) : int'(ptr)));
        end
    endtask

    task automatic run(input logic [7:0] s, input int n, input bit load);
        expect_reads(s, n, load);
        host.burst(s, n, load);
        check_reads();
    endtask

    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        conv_valid = 1'b0;
        conv_axis = 3'h0;
        fast_read = 1'b0;
        fifo_mode = 2'h0;
        axis_enable = 3'h7;
        fifo_status = 8'h00;
        cv = '{14'h0, 14'h0, 14'h0};
        hdv = '{14'h0, 14'h0, 14'h0};
        smp = '{14'h0, 14'h0, 14'h0};
        {rdy, ow, hr, ardy, aow, lat, ptr} = '0;
        last = -1;
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        run(8'h00, 7, 1);
        push(3'h7);
        settle();
        run(8'h00, 7, 1);
        run(8'h00, 1, 1);
        push(3'h7);
        push(3'h5);
        settle();
        run(8'h00, 1, 1);
        run(8'h01, 1, 1);
        run(8'h00, 1, 1);
        fast_read = 1'b1;
        run(8'h00, 4, 1);
        fast_read = 1'b0;
        // a new sample lands between the high and the low read of one axis
        push(3'h7);
        settle();
        run(8'h01, 1, 1);
        push(3'h7);
        settle();
        run(8'h00, 1, 0);
        run(8'h04, 1, 1);
        run(8'h06, 1, 1);
        axis_enable = 3'h3;
        push(3'h7);
        settle();
        run(8'h00, 7, 1);
        run(8'h00, 1, 1);
        axis_enable = 3'h7;
        run(8'h00, 2, 1);
        host.stop();
        ptr = 8'h00;
        run(8'h00, 1, 0);
        for (int m = 1; m < 4; m++) begin
            fifo_mode = 2'(m);
            fast_read = m[0];
            fifo_status = 8'($random(seed));
            for (int a = 0; a < 3; a++) hdv[a] = 14'($random(seed));
            run(8'h00, 7, 1);
        end
        fifo_mode = 2'h0;
        fast_read = 1'b0;
        // fill the staging buffer while strobes stall its drain
        expect_reads(8'h10, 12, 1);
        fork
            host.burst(8'h10, 12, 1);
            begin
                repeat (2) @(negedge ref_clk);
                repeat (4) push(3'h7);
                conv_valid = 1'b0;
                chk_bit("conv_ready", 1'b0, conv_ready);
            end
        join
        check_reads();
        settle();
        chk_bit("conv_ready", 1'b1, conv_ready);
        run(8'h00, 7, 1);
        repeat (10) begin
            r = 8'($random(seed));
            fast_read = r[3];
            push(r[2:0]);
            if (r[4]) push(r[7:5]);
            settle();
            run(8'h00, r[3] ? 4 : 7, 1);
        end
        end_of_test();
    end
endmodule

// >>> sim/host_read_model.sv
/*
 * Host side of the register read port: issues burst reads and stop
 * conditions and collects every returned byte.
 * Assumes the front end hands one strobe per byte and rd_valid one cycle later.
 */
`timescale 1ns/1ps

module host_read_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            addr_load,
    output logic [7:0]      addr_value,
    output logic            rd_strobe,
    output logic            stop_seen
);
    logic [7:0] got[$];

    initial begin
        addr_load = 1'b0;
        addr_value = 8'hff;
        rd_strobe = 1'b0;
        stop_seen = 1'b0;
    end

    // rd_valid stands one cycle, so it is sampled mid-cycle where it is settled
    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            got.push_back(rd_data);
        end
    end

    // strobes back to back; the address bus shows junk when not being loaded
    task automatic burst(input logic [7:0] start, input int n, input bit load);
        @(negedge ref_clk);
        addr_load = load;
        addr_value = load ? start : ~start;
        rd_strobe = 1'b1;
        repeat (n - 1) begin
            @(negedge ref_clk);
            addr_load = 1'b0;
            addr_value = ~start;
        end
        @(negedge ref_clk);
        addr_load = 1'b0;
        rd_strobe = 1'b0;
        @(negedge ref_clk);
    endtask

    // stop condition ends the burst addressing
    task automatic stop();
        @(negedge ref_clk);
        stop_seen = 1'b1;
        @(negedge ref_clk);
        stop_seen = 1'b0;
    endtask
endmodule
